// ==== rtl/fsx_pkg.sv ====
// Shared constants and types for the cyclic exchange link.
// Assumes a single 40 MHz clock shared by both ends.
package fsx_pkg;
    // ==========================================================
    // Frame layout
    localparam int FSX_WORDS = 4;
    localparam int FSX_WW = 16;
    localparam int FSX_CFG_W = 16;
    localparam logic [7:0] FSX_HDR_CFG = 8'ha5;
    localparam logic [7:0] FSX_HDR_REQ = 8'h5a;
    localparam logic [7:0] FSX_HDR_ACK = 8'hc3;
    localparam logic [7:0] FSX_HDR_RSP = 8'h3c;
    localparam logic [7:0] FSX_TRAILER = 8'h7e;
    localparam logic [15:0] FSX_CFG_RESET = 16'h0000;
    typedef logic [FSX_WORDS-1:0][FSX_WW-1:0] fsx_payload_t;
endpackage

// ==== rtl/fsx_if.sv ====
// Serial-free word link between node and master: one shared 16-bit line.
// Assumes both ends on i_clk; the line value resolves from enables.
`timescale 1ns/1ps
`default_nettype none
interface fsx_if;
    logic [15:0] m_dat;
    logic m_oe_n;
    logic [15:0] n_dat;
    logic n_oe_n;
    logic [15:0] line;
    logic line_vld;
    // ==========================================================
    // Shared line, active-low enables
    assign line = !m_oe_n ? m_dat : (!n_oe_n ? n_dat : 16'h0000);
    assign line_vld = !m_oe_n || !n_oe_n;
    modport node (input line, input line_vld, output n_dat, output n_oe_n);
    modport master (input line, input line_vld, output m_dat, output m_oe_n);
endinterface
`default_nettype wire

// ==== rtl/fsx_node.sv ====
// Node end of the cyclic exchange: config check, request receive, response.
// Assumes a master on the same clock driving fsx_if frames one word per cycle.
// Notes on behaviour
// RQ1: Matching config acknowledged, then data mode
// RQ2: Master configures before sending request frames
// RQ3: Frame is header, payload, trailer
// RQ4: Request payload four 16-bit words
// RQ5: Valid request answered with same-shaped response
// RQ6: Response payload four 16-bit words
// RQ7: Driver released after response ends
// RQ8: Master then addresses the next node
// RQ9: Frames carry error code, receiver checks
// RQ10: Good data written to destinations
// RQ11: Bad data discarded, no correction
// RQ12: Unique node address, master holds description
// RQ13: Mismatched config keeps node out of data
`timescale 1ns/1ps
`default_nettype none
module fsx_node
    import fsx_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Async reset, high
    fsx_if.node bus, // Shared line
    input wire logic [7:0] i_addr, // Own node address
    input wire logic [15:0] i_setup, // Local set-up
    input wire fsx_pkg::fsx_payload_t i_in_data, // Node-to-host words
    output logic [FSX_WORDS*FSX_WW-1:0] o_out_data, // Destination words
    output logic o_out_upd, // Destinations updated
    output logic o_err, // Error-check failure pulse
    output logic o_data_mode // In data exchange
);
    import fsx_pkg::*;

    typedef enum {S_IDLE, S_CFG, S_CRX, S_PAY, S_TRL, S_TX} fsx_nst_t;
    typedef struct packed {
        fsx_nst_t st;
        logic [2:0] idx;
        logic [3:0] tx_idx;
        logic [15:0] crc;
        logic [15:0] cfg;
        logic is_cfg;
        logic is_ack;
        fsx_payload_t rx;
        logic [15:0] tx_dat;
        logic tx_oe_n;
        logic [FSX_WORDS*FSX_WW-1:0] out;
        logic upd;
        logic err;
        logic dmode;
    } fsx_nstate_t;

    fsx_nstate_t r, next_r;

    // Error code: running xor-rotate over header and words
    function automatic logic [15:0] fsx_chk(input logic [15:0] c, input logic [15:0] w);
        fsx_chk = {c[14:0], c[15]} ^ w;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        next_r = r;
        next_r.upd = 1'b0;
        next_r.err = 1'b0;
        next_r.tx_oe_n = 1'b1;
        unique case (r.st)
            S_IDLE: begin
                // Header word: type in high byte, address in low byte
                if (bus.line_vld && bus.line[7:0] == i_addr) begin
                    next_r.crc = fsx_chk(16'h0000, bus.line);
                    next_r.idx = 3'd0;
                    if (bus.line[15:8] == FSX_HDR_CFG) begin
                        next_r.st = S_CFG;
                    end else if (bus.line[15:8] == FSX_HDR_REQ && r.dmode) begin // RQ13
                        next_r.st = S_PAY;
                    end
                end
            end
            S_CFG: begin
                if (bus.line_vld) begin
                    next_r.cfg = bus.line;
                    next_r.crc = fsx_chk(r.crc, bus.line);
                    next_r.st = S_CRX;
                end
            end
            S_CRX: begin
                next_r.st = S_IDLE;
                if (bus.line_vld) begin
                    if (bus.line == r.crc && r.cfg == i_setup) begin // RQ1
                        next_r.dmode = 1'b1;
                        next_r.is_ack = 1'b1;
                        next_r.tx_idx = 4'd0;
                        next_r.st = S_TX;
                    end else begin
                        next_r.dmode = 1'b0; // RQ13
                        next_r.err = bus.line != r.crc;
                    end
                end
            end
            S_PAY: begin
                if (bus.line_vld) begin
                    next_r.rx[r.idx[1:0]] = bus.line; // RQ4
                    next_r.crc = fsx_chk(r.crc, bus.line);
                    next_r.idx = r.idx + 3'd1;
                    if (r.idx == 3'(FSX_WORDS - 1)) begin
                        next_r.st = S_TRL;
                    end
                end
            end
            S_TRL: begin
                next_r.st = S_IDLE;
                if (bus.line_vld) begin
                    // Trailer word: marker high byte, error code low byte folded
                    if (bus.line == {FSX_TRAILER, r.crc[15:8] ^ r.crc[7:0]}) begin // RQ3 RQ9
                        next_r.out = r.rx; // RQ10
                        next_r.upd = 1'b1;
                        next_r.is_ack = 1'b0;
                        next_r.tx_idx = 4'd0;
                        next_r.st = S_TX; // RQ5
                    end else begin
                        next_r.err = 1'b1; // RQ11
                    end
                end
            end
            S_TX: begin
                next_r.tx_oe_n = 1'b0;
                next_r.tx_idx = r.tx_idx + 4'd1;
                if (r.tx_idx == 4'd0) begin
                    next_r.tx_dat = {(r.is_ack ? FSX_HDR_ACK : FSX_HDR_RSP), i_addr};
                    next_r.crc = fsx_chk(16'h0000, next_r.tx_dat);
                end else if (r.is_ack) begin
                    next_r.tx_dat = r.crc;
                    next_r.st = S_IDLE; // RQ7
                end else if (r.tx_idx <= 4'(FSX_WORDS)) begin
                    next_r.tx_dat = i_in_data[r.tx_idx[1:0] - 2'd1]; // RQ6
                    next_r.crc = fsx_chk(r.crc, next_r.tx_dat);
                end else begin
                    next_r.tx_dat = {FSX_TRAILER, r.crc[15:8] ^ r.crc[7:0]}; // RQ9
                    next_r.st = S_IDLE; // RQ7
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.st <= S_IDLE;
            r.cfg <= FSX_CFG_RESET;
            r.tx_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus.n_dat = r.tx_dat;
    assign bus.n_oe_n = r.tx_oe_n;
    assign o_out_data = r.out;
    assign o_out_upd = r.upd;
    assign o_err = r.err;
    assign o_data_mode = r.dmode;
endmodule // fsx_node
`default_nettype wire

// ==== rtl/fsx_master.sv ====
// Master end: configure one node, then run request/response exchanges.
// Assumes one node on fsx_if; the user sequences addresses across nodes.
`timescale 1ns/1ps
`default_nettype none
module fsx_master
    import fsx_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Async reset, high
    fsx_if.master bus, // Shared line
    input wire logic i_start, // Start one exchange pulse
    input wire logic i_cfg_go, // Send configuration pulse
    input wire logic [7:0] i_addr, // Target node address
    input wire logic [15:0] i_cfg, // Config description for node
    input wire fsx_pkg::fsx_payload_t i_out_data, // Host-to-node words
    output logic [FSX_WORDS*FSX_WW-1:0] o_in_data, // Node-to-host words
    output logic o_done, // Exchange finished pulse
    output logic o_err, // Bad or missing answer pulse
    output logic o_cfg_ok, // Node acknowledged config
    output logic o_busy // Transfer in progress
);
    import fsx_pkg::*;

    localparam logic [7:0] FSX_TMO = 8'd32;
    typedef enum {M_IDLE, M_TX, M_WAIT, M_RX} fsx_mst_t;
    typedef struct packed {
        fsx_mst_t st;
        logic cfg_mode;
        logic [3:0] idx;
        logic [7:0] tmo;
        logic [15:0] crc;
        logic [15:0] dat;
        logic oe_n;
        fsx_payload_t rx;
        logic [FSX_WORDS*FSX_WW-1:0] in;
        logic done;
        logic err;
        logic cfg_ok;
        logic busy;
    } fsx_mstate_t;

    fsx_mstate_t r, next_r;

    function automatic logic [15:0] fsx_chk(input logic [15:0] c, input logic [15:0] w);
        fsx_chk = {c[14:0], c[15]} ^ w;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.err = 1'b0;
        next_r.oe_n = 1'b1;
        unique case (r.st)
            M_IDLE: begin
                if (i_cfg_go || (i_start && r.cfg_ok)) begin // RQ2
                    next_r.cfg_mode = i_cfg_go;
                    if (i_cfg_go) begin
                        next_r.cfg_ok = 1'b0;
                    end
                    next_r.idx = 4'd0;
                    next_r.busy = 1'b1;
                    next_r.st = M_TX;
                end
            end
            M_TX: begin
                next_r.oe_n = 1'b0;
                next_r.idx = r.idx + 4'd1;
                if (r.idx == 4'd0) begin
                    next_r.dat = {(r.cfg_mode ? FSX_HDR_CFG : FSX_HDR_REQ), i_addr};
                    next_r.crc = fsx_chk(16'h0000, next_r.dat);
                end else if (r.cfg_mode && r.idx == 4'd1) begin
                    next_r.dat = i_cfg; // RQ12
                    next_r.crc = fsx_chk(r.crc, i_cfg);
                end else if (r.cfg_mode) begin
                    next_r.dat = r.crc;
                    next_r.st = M_WAIT;
                end else if (r.idx <= 4'(FSX_WORDS)) begin
                    next_r.dat = i_out_data[r.idx[1:0] - 2'd1]; // RQ3 RQ4
                    next_r.crc = fsx_chk(r.crc, next_r.dat);
                end else begin
                    next_r.dat = {FSX_TRAILER, r.crc[15:8] ^ r.crc[7:0]}; // RQ9
                    next_r.st = M_WAIT;
                end
                next_r.tmo = 8'd0;
            end
            M_WAIT: begin
                next_r.tmo = r.tmo + 8'd1;
                if (bus.line_vld && r.oe_n) begin
                    next_r.crc = fsx_chk(16'h0000, bus.line);
                    next_r.idx = 4'd0;
                    next_r.st = M_RX;
                    if (bus.line != {(r.cfg_mode ? FSX_HDR_ACK : FSX_HDR_RSP), i_addr}) begin
                        next_r.err = 1'b1;
                        next_r.busy = 1'b0;
                        next_r.st = M_IDLE;
                    end
                end else if (r.tmo == FSX_TMO) begin
                    // Silent node: give the line up so the next node can be served
                    next_r.err = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.st = M_IDLE; // RQ8
                end
            end
            M_RX: begin
                if (bus.line_vld) begin
                    next_r.idx = r.idx + 4'd1;
                    if (r.cfg_mode) begin
                        next_r.cfg_ok = bus.line == r.crc;
                        next_r.err = bus.line != r.crc;
                        next_r.done = bus.line == r.crc;
                        next_r.busy = 1'b0;
                        next_r.st = M_IDLE;
                    end else if (r.idx < 4'(FSX_WORDS)) begin
                        next_r.rx[r.idx[1:0]] = bus.line;
                        next_r.crc = fsx_chk(r.crc, bus.line);
                    end else begin
                        if (bus.line == {FSX_TRAILER, r.crc[15:8] ^ r.crc[7:0]}) begin // RQ9
                            next_r.in = r.rx;
                            next_r.done = 1'b1;
                        end else begin
                            next_r.err = 1'b1;
                        end
                        next_r.busy = 1'b0;
                        next_r.st = M_IDLE;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.st <= M_IDLE;
            r.oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus.m_dat = r.dat;
    assign bus.m_oe_n = r.oe_n;
    assign o_in_data = r.in;
    assign o_done = r.done;
    assign o_err = r.err;
    assign o_cfg_ok = r.cfg_ok;
    assign o_busy = r.busy;
endmodule // fsx_master
`default_nettype wire

// ==== bench/fsx_monitor.sv ====
// Checker for the shared word line between the master and node ends.
// Assumes the bench instantiates it beside the interface joining both ends.
`timescale 1ns/1ps
`default_nettype none
module fsx_monitor
    import fsx_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Async reset, high
    input wire logic [15:0] m_dat, // Master word
    input wire logic m_oe_n, // Master drive enable, low
    input wire logic [15:0] n_dat, // Node word
    input wire logic n_oe_n, // Node drive enable, low
    input wire logic [15:0] line, // Resolved word
    input wire logic line_vld // Someone drives
);
    logic [15:0] code;
    logic [2:0] idx;
    logic [7:0] last_addr;
    logic prev_vld;
    logic prev_m;
    logic first;
    // ==========================================================
    // Running error code of the frame now on the line
    // Driver change counts as a new frame, frames may abut
    assign first = line_vld && (!prev_vld || (prev_m != !m_oe_n));
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            code <= 16'h0000;
            idx <= 3'h0;
            last_addr <= 8'h00;
            prev_vld <= 1'b0;
            prev_m <= 1'b0;
        end else begin
            prev_vld <= line_vld;
            prev_m <= !m_oe_n;
            if (first) begin
                code <= line;
                idx <= 3'h1;
            end else if (line_vld) begin
                code <= {code[14:0], code[15]} ^ line;
                idx <= idx + 3'h1;
            end
            if (first && !m_oe_n) begin
                last_addr <= line[7:0];
            end
        end
    end
    // ==========================================================
    // Frame assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_req_start;
        $fell(m_oe_n) && m_dat[15:8] == FSX_HDR_REQ;
    endsequence
    sequence s_rsp_start;
        $fell(n_oe_n) && n_dat[15:8] == FSX_HDR_RSP;
    endsequence
    sequence s_ack_start;
        $fell(n_oe_n) && n_dat[15:8] == FSX_HDR_ACK;
    endsequence
    one_driver_a: assert property (m_oe_n || n_oe_n)
        else $error("both ends drive the line");
    req_length_a: assert property (s_req_start |-> !m_oe_n [*6] ##1 m_oe_n)
        else $error("request frame length wrong");
    rsp_length_a: assert property (s_rsp_start |-> !n_oe_n [*6] ##1 n_oe_n)
        else $error("response frame length or release wrong");
    ack_length_a: assert property (s_ack_start |-> ##1 !n_oe_n ##1 n_oe_n)
        else $error("acknowledge frame length wrong");
    ack_code_a: assert property (s_ack_start |-> ##1 n_dat == $past(n_dat))
        else $error("acknowledge error code wrong");
    answer_gap_a: assert property ($fell(n_oe_n) |-> $past(m_oe_n) && !$past(m_oe_n, 2))
        else $error("answer not one cycle after release");
    answer_kind_a: assert property ($fell(n_oe_n) |-> n_dat == {FSX_HDR_RSP, last_addr}
        || n_dat == {FSX_HDR_ACK, last_addr})
        else $error("answer header wrong");
    trailer_code_a: assert property (line_vld && !first && idx == 3'h5
        |-> line == {FSX_TRAILER, code[15:8] ^ code[7:0]})
        else $error("trailer code wrong");
endmodule // fsx_monitor
`default_nettype wire

// ==== bench/tb_top.sv ====
// Bench: master joined to a node, plus a second node fed raw frames by the bench.
// Assumes package, interface and both design ends are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fsx_pkg::*;
    typedef logic [15:0] fsx_frame_t [6];
    localparam logic [15:0] SETUP = 16'h1234;
    localparam logic [7:0] ADDR = 8'h21;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic start = 1'b0;
    logic cfg_go = 1'b0;
    logic [7:0] addr = ADDR;
    logic [15:0] cfg = 16'h0000;
    fsx_payload_t out_d = '0;
    fsx_payload_t in_d = '0;
    logic [63:0] m_in, n_out, n2_out;
    logic [63:0] last_out = '0;
    logic done, m_err, cfg_ok, busy, upd, n_err, mode, upd2, err2, mode2;
    int failures = 0;
    int compares = 0;
    int cyc = 0, n_upd = 0, n_upd2 = 0, n_err2 = 0, n_drv2 = 0, n_err1 = 0;
    fsx_if bus_a();
    fsx_if bus_b();
    fsx_master fsx_master_i (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_a.master), .i_start(start), .i_cfg_go(cfg_go),
        .i_addr(addr), .i_cfg(cfg), .i_out_data(out_d), .o_in_data(m_in), .o_done(done), .o_err(m_err),
        .o_cfg_ok(cfg_ok), .o_busy(busy));
    fsx_node fsx_node_i (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_a.node), .i_addr(ADDR), .i_setup(SETUP),
        .i_in_data(in_d), .o_out_data(n_out), .o_out_upd(upd), .o_err(n_err), .o_data_mode(mode));
    // Second node faces the bench so frames can be corrupted on purpose
    fsx_node fsx_node_i2 (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_b.node), .i_addr(ADDR), .i_setup(SETUP),
        .i_in_data(in_d), .o_out_data(n2_out), .o_out_upd(upd2), .o_err(err2), .o_data_mode(mode2));
    fsx_monitor fsx_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .m_dat(bus_a.m_dat), .m_oe_n(bus_a.m_oe_n),
        .n_dat(bus_a.n_dat), .n_oe_n(bus_a.n_oe_n), .line(bus_a.line), .line_vld(bus_a.line_vld));
    // ==========================================================
    // Clock, pulse counters and hang guard
    always #12.5 i_clk = ~i_clk;
    // Counted mid-cycle so registered pulses are never raced at their launch edge
    always @(negedge i_clk) begin
        cyc++;
        n_err1 += int'(n_err === 1'b1);
        n_upd += int'(upd === 1'b1);
        n_upd2 += int'(upd2 === 1'b1);
        n_err2 += int'(err2 === 1'b1);
        n_drv2 += int'(bus_b.n_oe_n === 1'b0);
        if (cyc == 2000) begin
            failures++;
            report_and_stop();
        end
    end
    // ==========================================================
    // Shared helpers
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic fsx_frame_t mk_frame(input fsx_payload_t d, input logic [15:0] hdr);
        fsx_frame_t f;
        logic [15:0] c;
        f[0] = hdr;
        c = hdr;
        for (int k = 0; k < 4; k++) begin
            f[k+1] = d[k];
            c = {c[14:0], c[15]} ^ d[k];
        end
        f[5] = {FSX_TRAILER, c[15:8] ^ c[7:0]};
        return f;
    endfunction
    task automatic send_b(input fsx_frame_t f, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge i_clk);
            bus_b.m_oe_n = 1'b0;
            bus_b.m_dat = f[k];
        end
        @(negedge i_clk);
        bus_b.m_oe_n = 1'b1;
        // Released line must not keep showing the last word
        bus_b.m_dat = ~f[n-1];
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_cfg(input logic [15:0] c, input logic ok);
        @(negedge i_clk);
        cfg = c;
        cfg_go = 1'b1;
        @(negedge i_clk);
        cfg_go = 1'b0;
        for (int k = 0; k < 60 && cfg_ok !== 1'b1 && m_err !== 1'b1; k++) @(negedge i_clk);
        check("cfg ack", cfg_ok, ok);
        check("data mode", mode, ok);
        $display("test cfg %h ended", c);
    endtask
    task automatic t_xfer(input logic [15:0] s, input logic ok, input logic bsy);
        int u;
        u = n_upd;
        for (int k = 0; k < 4; k++) begin
            out_d[k] = s + 16'(k);
            in_d[k] = ~s ^ 16'(k);
        end
        start = 1'b1;
        @(negedge i_clk);
        start = 1'b0;
        check("busy", busy, bsy);
        for (int k = 0; k < 60 && done !== 1'b1 && m_err !== 1'b1; k++) @(negedge i_clk);
        check("done", done, ok);
        check("master err", m_err, !ok && bsy);
        check("node err", n_err1, 0);
        if (ok) begin
            last_out = out_d;
            check("host words", m_in, in_d);
        end
        check("node words", n_out, last_out);
        check("updates", n_upd, u + int'(ok));
        @(negedge i_clk);
        $display("test exchange %h ended", s);
    endtask
    task automatic t_raw();
        fsx_frame_t f;
        fsx_frame_t r;
        int e;
        f = mk_frame(out_d, {FSX_HDR_REQ, ADDR});
        send_b(f, 6);
        repeat (6) @(negedge i_clk);
        check("raw early drive", n_drv2, 0);
        r[0] = {FSX_HDR_CFG, ADDR};
        r[1] = SETUP;
        r[2] = {r[0][14:0], r[0][15]} ^ SETUP;
        send_b(r, 3);
        repeat (4) @(negedge i_clk);
        check("raw mode", mode2, 1'b1);
        e = n_err2;
        f[5][0] = ~f[5][0];
        send_b(f, 6);
        repeat (6) @(negedge i_clk);
        check("raw err", n_err2, e + 1);
        check("raw drive", n_drv2, 2);
        check("raw kept", n2_out, 64'h0);
        f[5][0] = ~f[5][0];
        send_b(f, 6);
        for (int k = 0; k < 8 && bus_b.n_oe_n !== 1'b0; k++) @(negedge i_clk);
        for (int k = 0; k < 6; k++) begin
            r[k] = bus_b.n_dat;
            @(negedge i_clk);
        end
        f = mk_frame(in_d, {FSX_HDR_RSP, ADDR});
        for (int k = 0; k < 6; k++) check("raw reply", r[k], f[k]);
        check("raw words", n2_out, out_d);
        check("raw updates", n_upd2, 1);
        $display("test raw frames ended");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        bus_b.m_oe_n = 1'b1;
        bus_b.m_dat = 16'h0000;
        repeat (5) @(negedge i_clk);
        i_rst = 1'b0;
        t_xfer(16'h0100, 1'b0, 1'b0);
        t_cfg(16'h4321, 1'b0);
        t_cfg(SETUP, 1'b1);
        t_xfer(16'h1000, 1'b1, 1'b1);
        t_xfer(16'h2000, 1'b1, 1'b1);
        addr = 8'h22;
        t_xfer(16'h3000, 1'b0, 1'b1);
        addr = ADDR;
        t_raw();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
